//--- hdl/msr_defs.svh
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// register offsets
`define ADDR_DEVICE_STATUS    8'h05
`define ADDR_INTERRUPT_ENABLE 8'h06
`define ADDR_OPERATING_MODE   8'h07
`define ADDR_MOTION_CONTROL   8'h09
`define ADDR_INTERRUPT_STATUS 8'h14

// reset values
`define RST_DEVICE_STATUS     8'h00
`define RST_INTERRUPT_ENABLE  8'h00
`define RST_OPERATING_MODE    8'h00
`define RST_MOTION_CONTROL    8'h00

// device_status fields
`define DS_STATE_LO           0
`define DS_RES_BIT            2
`define DS_WDT_BIT            4
`define DS_OTP_BIT            7

// interrupt_enable fields
`define IE_TILT_BIT           0
`define IE_FLIP_BIT           1
`define IE_ANYM_BIT           2
`define IE_SHAKE_BIT          3
`define IE_T35_BIT            4
`define IE_AUTOCLR_BIT        6
`define IE_SAMPLE_BIT         7

// operating_mode fields
`define OM_STATE_LO           0
`define OM_WDT_LOW_BIT        4
`define OM_WDT_HIGH_BIT       5
`define OM_WRITE_MASK         8'h33

// motion control fields
`define MC_TF_BIT             0
`define MC_ANYM_BIT           2
`define MC_SHAKE_BIT          3
`define MC_T35_BIT            4

// interrupt status flag positions
`define IS_SAMPLE_BIT         7

// stall watchdog: time in microseconds and derived cycles at 10 MHz
`define WDT_STALL_US          1000
`define CLK_MHZ               10
`define WDT_STALL_CYCLES      (`WDT_STALL_US * `CLK_MHZ)

`endif

//--- hdl/msr_pkg.sv
package msr_pkg;

    // reported operating states
    typedef enum logic [1:0] {
        ST_SLEEP   = 2'b00,
        ST_WAKE    = 2'b01,
        ST_RESV    = 2'b10,
        ST_STANDBY = 2'b11
    } op_state_t;

    // watchdog sequencer, one-hot
    typedef enum logic [2:0] {
        WD_IDLE  = 3'b001,
        WD_COUNT = 3'b010,
        WD_FIRE  = 3'b100
    } wd_state_t;

endpackage : msr_pkg

//--- hdl/stall_watchdog.sv
`timescale 1ns/1ns
`include "msr_defs.svh"

module stall_watchdog
    import msr_pkg::*;
#(
    parameter int unsigned LIMIT = `WDT_STALL_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // watched line, already synchronised
    input  wire logic enable_i,
    input  wire logic level_i,
    input  wire logic watch_high_i,
    // timeout event
    output logic      timeout_o
);

    typedef struct packed {
        wd_state_t   st;
        logic [31:0] cnt;
    } wd_reg_t;

    wd_reg_t r;
    wd_reg_t next_r;
    logic    at_level;

    // count while the line sits at the watched level
    always_comb begin
        next_r   = r;
        at_level = enable_i && (level_i == watch_high_i);
        case (r.st)
            WD_IDLE: begin
                next_r.cnt = 32'h0000_0000;
                if (at_level) begin
                    next_r.st = WD_COUNT;
                end
            end
            WD_COUNT: begin
                if (!at_level) begin
                    next_r.st = WD_IDLE;
                end else if (r.cnt >= LIMIT - 1) begin
                    next_r.st = WD_FIRE;
                end else begin
                    next_r.cnt = r.cnt + 32'h0000_0001;
                end
            end
            WD_FIRE: begin
                // one event per stall, rearm once released
                if (!at_level) begin
                    next_r.st = WD_IDLE;
                end
            end
            default: begin
                next_r.st = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r.st  <= WD_IDLE;
            r.cnt <= 32'h0000_0000;
        end else begin
            r <= next_r;
        end
    end

    assign timeout_o = (r.st == WD_COUNT) && at_level && (r.cnt >= LIMIT - 1);

endmodule : stall_watchdog

//--- hdl/irq_gate.sv
`timescale 1ns/1ns
`include "msr_defs.svh"

module irq_gate
    import msr_pkg::*;
(
    // control register contents
    input  wire logic [7:0] int_enable_i,
    input  wire logic [7:0] motion_ctrl_i,
    // raw motion conditions: tilt, flip, anym, shake, tilt35
    input  wire logic [4:0] raw_i,
    // gated conditions
    output logic      [4:0] gated_o
);

    logic tf_on;
    logic am_on;

    // feature enables combined with interrupt enables
    always_comb begin
        tf_on = motion_ctrl_i[`MC_TF_BIT];
        am_on = motion_ctrl_i[`MC_ANYM_BIT];
        gated_o[0] = raw_i[0] && int_enable_i[`IE_TILT_BIT] && tf_on;
        gated_o[1] = raw_i[1] && int_enable_i[`IE_FLIP_BIT] && tf_on;
        gated_o[2] = raw_i[2] && int_enable_i[`IE_ANYM_BIT] && am_on;
        gated_o[3] = raw_i[3] && int_enable_i[`IE_SHAKE_BIT] && am_on
                     && motion_ctrl_i[`MC_SHAKE_BIT];
        gated_o[4] = raw_i[4] && int_enable_i[`IE_T35_BIT] && am_on
                     && motion_ctrl_i[`MC_T35_BIT];
    end

endmodule : irq_gate

//--- hdl/mode_status_interrupt_regs.sv
`timescale 1ns/1ns
`include "msr_defs.svh"

module mode_status_interrupt_regs
    import msr_pkg::*;
#(
    parameter int unsigned WDT_LIMIT = `WDT_STALL_CYCLES
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // register access from the serial engine
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // serial clock pin
    input  wire logic       scl_i,
    // device state inputs
    input  wire logic       otp_busy_i,
    input  wire logic       sample_done_i,
    input  wire logic [4:0] motion_raw_i,
    input  wire logic [2:0] fifo_irq_i,
    input  wire logic [2:0] fifo_irq_en_i,
    // outputs to the rest of the device
    output logic      [1:0] op_state_o,
    output logic            clocks_run_o,
    output logic            sampling_o,
    output logic            serial_reset_o,
    output logic      [7:0] motion_ctrl_o,
    output logic      [7:0] int_status_o,
    output logic            irq_o
);

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] otp_sync;
        logic [7:0] int_enable;
        logic [7:0] op_mode;
        logic [7:0] motion_ctrl;
        logic       wdt_flag;
        logic [7:0] int_status;
        logic [1:0] cur_state;
        logic       serial_reset;
        logic [7:0] rdata;
    } regs_t;

    regs_t r;
    regs_t next_r;
    logic  [4:0] gated;
    logic        wdt_low_hit;
    logic        wdt_high_hit;
    logic        wdt_event;
    logic        wr_mode;
    logic        wr_ie;
    logic        wr_mc;
    logic        wr_is;
    logic        rd_status;
    logic [7:0]  status_word;
    logic        fifo_any;

    // address decode used by both read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    irq_gate u_gate (
        .int_enable_i  (r.int_enable),
        .motion_ctrl_i (r.motion_ctrl),
        .raw_i         (motion_raw_i),
        .gated_o       (gated)
    );

    // low-level stall watcher
    stall_watchdog #(.LIMIT(WDT_LIMIT)) u_wdt_low (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .enable_i     (r.op_mode[`OM_WDT_LOW_BIT]),
        .level_i      (r.scl_sync[1]),
        .watch_high_i (1'b0),
        .timeout_o    (wdt_low_hit)
    );

    // high-level stall watcher
    stall_watchdog #(.LIMIT(WDT_LIMIT)) u_wdt_high (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .enable_i     (r.op_mode[`OM_WDT_HIGH_BIT]),
        .level_i      (r.scl_sync[1]),
        .watch_high_i (1'b1),
        .timeout_o    (wdt_high_hit)
    );

    // decode strobes
    always_comb begin
        wr_mode   = reg_wr_i && hit(reg_addr_i, `ADDR_OPERATING_MODE);
        wr_ie     = reg_wr_i && hit(reg_addr_i, `ADDR_INTERRUPT_ENABLE);
        wr_mc     = reg_wr_i && hit(reg_addr_i, `ADDR_MOTION_CONTROL);
        wr_is     = reg_wr_i && hit(reg_addr_i, `ADDR_INTERRUPT_STATUS);
        rd_status = reg_rd_i && hit(reg_addr_i, `ADDR_DEVICE_STATUS);
        wdt_event = wdt_low_hit || wdt_high_hit;
        fifo_any  = |(fifo_irq_i & fifo_irq_en_i);
    end

    // device_status image
    always_comb begin
        status_word = `RST_DEVICE_STATUS;
        status_word[`DS_STATE_LO +: 2] = r.cur_state;
        status_word[`DS_RES_BIT] = 1'b0;
        status_word[`DS_WDT_BIT] = r.wdt_flag;
        status_word[`DS_OTP_BIT] = r.otp_sync[1];
    end

    // next state of all registers
    always_comb begin
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], scl_i};
        next_r.otp_sync = {r.otp_sync[0], otp_busy_i};
        // mode register writable in any state
        if (wr_mode) begin
            next_r.op_mode = reg_wdata_i & `OM_WRITE_MASK;
        end
        if (wr_ie) begin
            next_r.int_enable = reg_wdata_i;
        end
        if (wr_mc) begin
            next_r.motion_ctrl = reg_wdata_i;
        end
        // reported state follows written sleep and wake, standby reports 00, reserved keeps old
        case (op_state_t'(r.op_mode[`OM_STATE_LO +: 2]))
            ST_SLEEP:   next_r.cur_state = 2'b00;
            ST_WAKE:    next_r.cur_state = 2'b01;
            ST_STANDBY: next_r.cur_state = 2'b00;
            default:    next_r.cur_state = r.cur_state;
        endcase
        // watchdog flag: read clears, event wins
        if (rd_status) begin
            next_r.wdt_flag = 1'b0;
        end
        if (wdt_event) begin
            next_r.wdt_flag = 1'b1;
        end
        next_r.serial_reset = wdt_event;
        // interrupt status: host write or auto clear, then set
        if (r.int_enable[`IE_AUTOCLR_BIT]) begin
            next_r.int_status[4:0] = gated;
            if (!sampling_o) begin
                next_r.int_status[`IS_SAMPLE_BIT] = 1'b0;
            end
        end else if (wr_is) begin
            next_r.int_status = 8'h00;
        end
        next_r.int_status[4:0] = next_r.int_status[4:0] | gated;
        if (sample_done_i && r.int_enable[`IE_SAMPLE_BIT]) begin
            next_r.int_status[`IS_SAMPLE_BIT] = 1'b1;
        end
        // read data
        if (reg_rd_i) begin
            if (hit(reg_addr_i, `ADDR_DEVICE_STATUS)) begin
                next_r.rdata = status_word;
            end else if (hit(reg_addr_i, `ADDR_INTERRUPT_ENABLE)) begin
                next_r.rdata = r.int_enable;
            end else if (hit(reg_addr_i, `ADDR_OPERATING_MODE)) begin
                next_r.rdata = r.op_mode;
            end else if (hit(reg_addr_i, `ADDR_MOTION_CONTROL)) begin
                next_r.rdata = r.motion_ctrl;
            end else if (hit(reg_addr_i, `ADDR_INTERRUPT_STATUS)) begin
                next_r.rdata = r.int_status;
            end else begin
                next_r.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r.scl_sync     <= 2'b11;
            r.otp_sync     <= 2'b00;
            r.int_enable   <= `RST_INTERRUPT_ENABLE;
            r.op_mode      <= `RST_OPERATING_MODE;
            r.motion_ctrl  <= `RST_MOTION_CONTROL;
            r.wdt_flag     <= 1'b0;
            r.int_status   <= 8'h00;
            r.cur_state    <= 2'b00;
            r.serial_reset <= 1'b0;
            r.rdata        <= 8'h00;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign op_state_o     = r.op_mode[`OM_STATE_LO +: 2];
    assign clocks_run_o   = (r.op_mode[1:0] == 2'b01)
                            || (r.op_mode[1:0] == 2'b11);
    assign sampling_o     = (r.op_mode[1:0] == 2'b01);
    assign serial_reset_o = r.serial_reset;
    assign motion_ctrl_o  = r.motion_ctrl;
    assign int_status_o   = r.int_status;
    assign reg_rdata_o    = r.rdata;
    assign irq_o          = (|r.int_status) || fifo_any;

    // flag drops one cycle after a read with no event
    a_wdt_read_clear: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        rd_status && !wdt_event |=> !r.wdt_flag)
        else $error("watchdog flag survived status read");

    // an event records the flag and resets the serial target
    a_wdt_event_set: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wdt_event |=> r.wdt_flag && r.serial_reset)
        else $error("watchdog event not recorded");

    // resolution bit reads back zero on every status read
    a_res_zero: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        rd_status |=> !reg_rdata_o[`DS_RES_BIT])
        else $error("resolution indicator not zero");

    // wake written, wake reported two cycles on
    a_state_wake: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_mode && reg_wdata_i[1:0] == 2'b01 |=> ##1 r.cur_state == 2'b01)
        else $error("wake not reported");

    // sleep written, clocks-stopped code reported
    a_state_sleep: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_mode && reg_wdata_i[1:0] == 2'b00 |=> ##1 r.cur_state == 2'b00)
        else $error("sleep not reported");

    // standby has no status code of its own, reports 00
    a_state_standby: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_mode && reg_wdata_i[1:0] == 2'b11 |=> ##1 r.cur_state == 2'b00)
        else $error("standby not reported as 00");

    // reserved code written, previous report kept
    a_state_keep: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_mode && reg_wdata_i[1:0] == 2'b10 |=> ##1 $stable(r.cur_state))
        else $error("reserved write changed report");

    // reserved codes never reported
    a_state_resv: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !r.cur_state[1])
        else $error("reserved state code reported");

    // busy bit follows the pin two cycles late
    a_otp_busy: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        otp_busy_i ##2 otp_busy_i[*1]
        |-> status_word[`DS_OTP_BIT] == $past(otp_busy_i, 2))
        else $error("busy bit mismatch");

    // tilt only with its enable and the tilt/flip feature
    a_tilt_gate: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        gated[0] |-> r.motion_ctrl[`MC_TF_BIT]
        && r.int_enable[`IE_TILT_BIT])
        else $error("tilt passed without enables");

    // flip only with its enable and the tilt/flip feature
    a_flip_gate: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        gated[1] |-> r.motion_ctrl[`MC_TF_BIT]
        && r.int_enable[`IE_FLIP_BIT])
        else $error("flip passed without enables");

    // any-motion only with its feature enable
    a_anym_gate: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        gated[2] |-> r.motion_ctrl[`MC_ANYM_BIT])
        else $error("any-motion passed without feature");

    // shake needs its own and the any-motion feature
    a_shake_gate: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        gated[3] |-> r.motion_ctrl[`MC_ANYM_BIT]
        && r.motion_ctrl[`MC_SHAKE_BIT])
        else $error("shake passed without features");

    // tilt-35 needs its own and the any-motion feature
    a_t35_gate: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        gated[4] |-> r.motion_ctrl[`MC_ANYM_BIT]
        && r.motion_ctrl[`MC_T35_BIT])
        else $error("tilt-35 passed without features");

    // without auto-clear a pending tilt waits for the host
    a_latch_hold: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !r.int_enable[`IE_AUTOCLR_BIT] && !wr_is && !wr_ie
        && r.int_status[0] |=> r.int_status[0])
        else $error("latched interrupt lost");

    // a status write with nothing pending empties the register
    a_status_clear: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !r.int_enable[`IE_AUTOCLR_BIT] && wr_is && gated == 5'h00
        && !sample_done_i |=> r.int_status == 8'h00)
        else $error("status write did not clear");

    // with auto-clear the motion bits track their conditions
    a_auto_follow: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        r.int_enable[`IE_AUTOCLR_BIT]
        |=> r.int_status[4:0] == $past(gated))
        else $error("auto-clear bits not tracking");

    // enabled sample pulse raises the sample flag
    a_sample_set: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        sample_done_i && r.int_enable[`IE_SAMPLE_BIT]
        |=> r.int_status[`IS_SAMPLE_BIT])
        else $error("sample flag not set");

    // no sample pulse, a clear sample flag stays clear
    a_sample_quiet: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !sample_done_i && !r.int_status[`IS_SAMPLE_BIT]
        |=> !r.int_status[`IS_SAMPLE_BIT])
        else $error("sample flag set without a sample");

    // enabled fifo sources reach the line past the enable register
    a_fifo_pass: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (|(fifo_irq_i & fifo_irq_en_i)) |-> irq_o)
        else $error("fifo source did not raise the line");

    // mode accepts writes in every state
    a_mode_write: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_mode |=> r.op_mode == ($past(reg_wdata_i) & `OM_WRITE_MASK))
        else $error("mode write lost");

endmodule : mode_status_interrupt_regs

//--- dv/host_model.sv
`timescale 1ns/1ns

module host_model (
    // clock
    input  wire logic       clk_i,
    // register access toward the device
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i,
    // serial clock line, pulled up while idle
    output logic            scl_o
);
    // idle bus, serial clock at its pull-up level
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
        scl_o       = 1'b1;
    end

    // one-cycle write strobe; write data inverted once the strobe drops
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~d;
    endtask : wr_reg

    // one-cycle read strobe, data taken one cycle later
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask : rd_reg
endmodule : host_model

//--- dv/mode_status_interrupt_regs_test.sv
`timescale 1ns/1ns

`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module mode_status_interrupt_regs_test;
    import msr_pkg::*;

    logic       clk;
    logic       reset_n;
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       rd;
    logic [7:0] rdata;
    logic       scl;
    logic       otp_busy;
    logic       sample_done;
    logic [4:0] raw;
    logic [2:0] fifo_irq;
    logic [2:0] fifo_en;
    logic [1:0] op_state;
    logic       clocks_run;
    logic       sampling;
    logic       serial_reset;
    logic [7:0] motion_ctrl;
    logic [7:0] int_status;
    logic       irq;
    int         errors;
    int         total_checks;
    int         pulses;
    int         seed;

    mode_status_interrupt_regs #(.WDT_LIMIT(8)) dut_u (
        .clk_i          (clk),
        .reset_n_i      (reset_n),
        .reg_addr_i     (addr),
        .reg_wr_i       (wr),
        .reg_wdata_i    (wdata),
        .reg_rd_i       (rd),
        .reg_rdata_o    (rdata),
        .scl_i          (scl),
        .otp_busy_i     (otp_busy),
        .sample_done_i  (sample_done),
        .motion_raw_i   (raw),
        .fifo_irq_i     (fifo_irq),
        .fifo_irq_en_i  (fifo_en),
        .op_state_o     (op_state),
        .clocks_run_o   (clocks_run),
        .sampling_o     (sampling),
        .serial_reset_o (serial_reset),
        .motion_ctrl_o  (motion_ctrl),
        .int_status_o   (int_status),
        .irq_o          (irq)
    );

    host_model host_u (
        .clk_i       (clk),
        .reg_addr_o  (addr),
        .reg_wr_o    (wr),
        .reg_wdata_o (wdata),
        .reg_rd_o    (rd),
        .reg_rdata_i (rdata),
        .scl_o       (scl)
    );

    // clock generator
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // counts serial target reset pulses, sole writer of the count
    always @(posedge clk) begin
        if (!reset_n) begin
            pulses <= 0;
        end else if (serial_reset === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    // expected gated motion conditions
    function automatic logic [4:0] gate(logic [7:0] ie, logic [7:0] mc,
                                        logic [4:0] r);
        gate[0] = ie[0] & mc[0] & r[0];
        gate[1] = ie[1] & mc[0] & r[1];
        gate[2] = ie[2] & mc[2] & r[2];
        gate[3] = ie[3] & mc[3] & mc[2] & r[3];
        gate[4] = ie[4] & mc[4] & mc[2] & r[4];
    endfunction : gate

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, errors);
    endtask : end_test

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // hang guard, about twenty-five times the expected run
    initial begin
        #1_000_000;
        errors++;
        print_verdict();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] w;
        logic [7:0] ie;
        logic [7:0] mc;
        logic [1:0] st[4];
        logic [1:0] rep[4];
        logic [7:0] adr[6];
        int         base;
        st  = '{2'b01, 2'b10, 2'b11, 2'b00};
        rep = '{2'b01, 2'b01, 2'b00, 2'b00};
        adr = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h14, 8'h20};
        seed = 32'h0d83;
        errors = 0;
        total_checks = 0;
        reset_n = 1'b0;
        otp_busy = 1'b0;
        sample_done = 1'b0;
        raw = 5'h00;
        fifo_irq = 3'h0;
        fifo_en = 3'h0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;

        // reset values and an unmapped read
        foreach (adr[i]) begin
            host_u.rd_reg(adr[i], d);
            `CHK(d, 8'h00)
        end
        end_test("reset");

        // every state code, each written once in turn from the previous one
        for (int i = 0; i < 4; i++) begin
            w = ($random(seed) & 8'hcc) | {6'h00, st[i]};
            host_u.wr_reg(8'h07, w);
            host_u.rd_reg(8'h07, d);
            `CHK(d, w & 8'h33)
            `CHK(op_state, st[i])
            `CHK(sampling, st[i] == 2'b01)
            `CHK(clocks_run, st[i][0])
            host_u.rd_reg(8'h05, d);
            `CHK(d[1:0], rep[i])
            `CHK(d[2], 1'b0)
        end
        end_test("mode");

        // one-time memory busy flag
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            otp_busy <= i[0];
            repeat (4) @(posedge clk);
            host_u.rd_reg(8'h05, d);
            `CHK(d[7], i[0])
        end
        end_test("otp");

        // gating with auto-clear, corner cases then random
        for (int i = 0; i < 24; i++) begin
            ie = ($random(seed) & 8'h1f) | 8'h40;
            mc = $random(seed);
            w = $random(seed);
            if (i < 2) begin
                ie = 8'h5f;
                mc = i ? 8'h1d : 8'h18;
                w = 8'h1f;
            end
            host_u.wr_reg(8'h06, ie);
            host_u.wr_reg(8'h09, mc);
            raw <= w[4:0];
            repeat (3) @(posedge clk);
            #1;
            `CHK(int_status[4:0], gate(ie, mc, w[4:0]))
            `CHK(motion_ctrl, mc)
            `CHK(irq, |gate(ie, mc, w[4:0]))
        end
        end_test("gating");

        // latched tilt until the status write
        host_u.wr_reg(8'h06, 8'h01);
        host_u.wr_reg(8'h09, 8'h01);
        raw <= 5'h00;
        host_u.wr_reg(8'h14, 8'h00);
        @(posedge clk);
        raw <= 5'h01;
        @(posedge clk);
        raw <= 5'h00;
        repeat (3) @(posedge clk);
        #1;
        `CHK(int_status[0], 1'b1)
        host_u.wr_reg(8'h14, 8'h00);
        @(posedge clk);
        #1;
        `CHK(int_status, 8'h00)
        end_test("latch");

        // sample interrupt off then on
        for (int i = 0; i < 2; i++) begin
            host_u.wr_reg(8'h06, i ? 8'h80 : 8'h00);
            @(posedge clk);
            sample_done <= 1'b1;
            @(posedge clk);
            sample_done <= 1'b0;
            #1;
            `CHK(int_status[7], i[0])
            `CHK(irq, i[0])
            host_u.wr_reg(8'h14, 8'h00);
        end
        end_test("sample");

        // fifo sources bypass the enable register
        host_u.wr_reg(8'h06, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            w = $random(seed);
            fifo_irq <= w[2:0];
            fifo_en <= w[5:3];
            repeat (2) @(posedge clk);
            #1;
            `CHK(irq, |(w[2:0] & w[5:3]))
        end
        fifo_irq <= 3'h0;
        end_test("fifo");

        // stall watchdogs: disabled, low, high
        @(posedge clk);
        base = pulses;
        host_u.scl_o <= 1'b0;
        repeat (30) @(posedge clk);
        `CHK(pulses - base, 0)
        host_u.wr_reg(8'h07, 8'h10);
        repeat (5) @(posedge clk);
        `CHK(pulses - base, 0)
        repeat (25) @(posedge clk);
        `CHK(pulses - base, 1)
        host_u.scl_o <= 1'b1;
        host_u.rd_reg(8'h05, d);
        `CHK(d[4], 1'b1)
        host_u.rd_reg(8'h05, d);
        `CHK(d[4], 1'b0)
        base = pulses;
        host_u.wr_reg(8'h07, 8'h20);
        repeat (30) @(posedge clk);
        `CHK(pulses - base, 1)
        host_u.wr_reg(8'h07, 8'h00);
        host_u.rd_reg(8'h05, d);
        `CHK(d[4], 1'b1)
        end_test("watchdog");

        print_verdict();
    end
endmodule : mode_status_interrupt_regs_test
